// ==== src/ttc_pkg.sv ====
// Shared constants, types and decode functions for the thermometer
// two-wire command port.
// Assumes a single 200 MHz system clock samples the bus pins.
package ttc_pkg;
  localparam logic [3:0] OWN_ADDR_HI = 4'h9;
  localparam logic [7:0] CMD_START = 8'h51;
  localparam logic [7:0] CMD_STOP = 8'h22;
  localparam logic [7:0] CMD_RECALL = 8'hB8;
  localparam logic [7:0] CMD_COPY = 8'h48;
  localparam logic [7:0] CMD_POR = 8'h54;
  localparam logic [7:0] MAP_FIRST = 8'hA0;
  localparam logic [7:0] MAP_LAST = 8'hAD;
  localparam logic [7:0] UNDEF_A = 8'hA8;
  localparam logic [7:0] UNDEF_B = 8'hA9;
  localparam logic [7:0] TEMP_MSB = 8'hAA;
  localparam logic [7:0] TEMP_LSB = 8'hAB;
  localparam logic [7:0] CFG_ADDR = 8'hAC;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [7:0] PTR_MAX = 8'hFF;
  localparam int MAP_SIZE = 14;
  localparam int CFG_RES_HI = 3;
  localparam int CFG_RES_LO = 2;
  localparam int CFG_SINGLE = 0;
  localparam logic [7:0] CFG_FACTORY = 8'h0C;
  localparam logic [7:0] NV_FACTORY = 8'h00;
  localparam logic [3:0] RES_BASE_BITS = 4'hA;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Conversion time unit is the 10-bit figure; each wider mode doubles it
  localparam int T_CONV_BASE_MS = 25;
  localparam int MCLK_KHZ = 200000;
  localparam int CONV_BASE_CYC = T_CONV_BASE_MS * MCLK_KHZ;
  // Pin vector layout inside the synchroniser
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_ADDR = 2;
  localparam int PIN_W = 5;
  localparam logic [4:0] PIN_RESET = 5'h03;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_CTRL = 4'h1,
    ST_CACK = 4'h2,
    ST_WORD = 4'h3,
    ST_WACK = 4'h4,
    ST_DATA = 4'h5,
    ST_DACK = 4'h6,
    ST_TX = 4'h7,
    ST_MACK = 4'h8,
    ST_SKIP = 4'h9
  } ttc_state_e;

  function automatic logic ttc_in_map(input logic [7:0] a);
    return (a >= MAP_FIRST) && (a <= MAP_LAST);
  endfunction

  // Locations that bus writes, copy and recall may touch
  function automatic logic ttc_is_nv(input logic [7:0] a);
    return ttc_in_map(a) && (a != UNDEF_A) && (a != UNDEF_B) &&
           (a != TEMP_MSB) && (a != TEMP_LSB);
  endfunction

  function automatic logic [3:0] ttc_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - MAP_FIRST;
    return d[3:0];
  endfunction

  function automatic logic [7:0] ttc_factory(input int i);
    return (MAP_FIRST + 8'(i) == CFG_ADDR) ? CFG_FACTORY : NV_FACTORY;
  endfunction
endpackage

// ==== src/ttc_pin_if.sv ====
// Synchronised bus levels and bus events passed from the pin
// synchroniser to the command port logic.
// Assumes both ends run on mclk.
`timescale 1ns/1ps
interface ttc_pin_if;
  logic scl;
  logic sda;
  logic [2:0] addr;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  modport src (output scl, sda, addr, scl_rise, scl_fall, start, stop);
  modport sink (input scl, sda, addr, scl_rise, scl_fall, start, stop);
endinterface

// ==== src/ttc_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter and bus event
// detection for SCL, SDA and the address select pins.
// Assumes all pins are asynchronous to mclk.
`timescale 1ns/1ps
module ttc_pin_sync
  import ttc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic addr_pin_bit2,
  input wire logic addr_pin_bit1,
  input wire logic addr_pin_bit0,
  ttc_pin_if.src pins
);
  logic [PIN_W-1:0] raw;
  logic [PIN_W-1:0] s1_r, s2_r, s3_r, lvl_r, lvl_nxt;
  logic rise_r, fall_r, sta_r, sto_r;
  logic rise_nxt, fall_nxt, sta_nxt, sto_nxt;

  assign raw = {addr_pin_bit2, addr_pin_bit1, addr_pin_bit0, sda_in, scl_in};

  // A level changes only when stages two and three agree
  genvar g;
  for (g = 0; g < PIN_W; g++) begin : g_filt
    assign lvl_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : lvl_r[g];
  end

  // Events compare the filtered level against its new value
  always_comb begin
    rise_nxt = lvl_nxt[PIN_SCL] & ~lvl_r[PIN_SCL];
    fall_nxt = ~lvl_nxt[PIN_SCL] & lvl_r[PIN_SCL];
    // Data edges count as start/stop only with SCL steady high
    sta_nxt = lvl_nxt[PIN_SCL] & lvl_r[PIN_SCL] &
              ~lvl_nxt[PIN_SDA] & lvl_r[PIN_SDA];
    sto_nxt = lvl_nxt[PIN_SCL] & lvl_r[PIN_SCL] &
              lvl_nxt[PIN_SDA] & ~lvl_r[PIN_SDA];
  end

  // Reset to an idle bus so no false start appears at release
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= PIN_RESET;
      s2_r <= PIN_RESET;
      s3_r <= PIN_RESET;
      lvl_r <= PIN_RESET;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
      sta_r <= 1'b0;
      sto_r <= 1'b0;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
      sta_r <= sta_nxt;
      sto_r <= sto_nxt;
    end
  end

  assign pins.scl = lvl_r[PIN_SCL];
  assign pins.sda = lvl_r[PIN_SDA];
  assign pins.addr = lvl_r[PIN_ADDR+2:PIN_ADDR];
  assign pins.scl_rise = rise_r;
  assign pins.scl_fall = fall_r;
  assign pins.start = sta_r;
  assign pins.stop = sto_r;
endmodule

// ==== src/ttc_top.sv ====
// Two-wire slave command port of a digital thermometer: bus slave,
// shadow RAM, nonvolatile copy, command decode and conversion timer.
// Assumes an open-drain SDA resolved outside and SCL from the master.
`timescale 1ns/1ps
// Summary of operation
// - Resolution bits pick 10..13 bit width and 25..200 ms time.
// - Bytes travel MSB first, one bit per SCL period.
// - Answer only address 1001 plus the three address pins.
// - First byte is seven address bits then direction, 1 read.
// - Receiver pulls SDA low the whole ninth period; sender lets go.
// - SDA falling with SCL high is start, also repeated start.
// - SDA rising with SCL high is stop; bus then idles.
// - SDA changes only while SCL is low, except start and stop.
// - Each byte is eight data bits plus one ack bit.
// - Ack matching control byte and the command or address byte.
// - Writes load the pointer, store each byte, ack, increment.
// - Writes to A8h and A9h change nothing.
// - Bus writes hit shadow RAM; only copy command updates EEPROM.
// - Command 48h copies shadow RAM to EEPROM.
// - Read: set address, restart with direction 1, data follows ack.
// - Reads past ADh return FFh.
// - Command 51h starts one or continuous conversions.
// - Command 22h stops continuous conversion; no effect in one-shot.
// - Command B8h reloads shadow RAM from EEPROM.
// - Command 54h stops conversion and restores power-up state.
// - Single conversion bit set means one-shot; factory value zero.
module ttc_top
  import ttc_pkg::*;
#(
  parameter int unsigned CONV_UNIT_CYC = CONV_BASE_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_o,
  output logic sda_oe,
  input wire logic addr_pin_bit2,
  input wire logic addr_pin_bit1,
  input wire logic addr_pin_bit0,
  input wire logic [15:0] temp_in,
  output logic converting,
  output logic conv_done,
  output logic [3:0] conv_bits,
  output logic resolution_select_hi,
  output logic resolution_select_lo,
  output logic single_conversion_mode,
  output logic ee_copy,
  output logic ee_recall
);
  ttc_pin_if pins ();

  ttc_pin_sync u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .addr_pin_bit2(addr_pin_bit2),
    .addr_pin_bit1(addr_pin_bit1),
    .addr_pin_bit0(addr_pin_bit0),
    .pins(pins)
  );

  ttc_state_e st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt, tx_r, tx_nxt;
  logic rd_r, rd_nxt, oe_r, oe_nxt;
  logic [7:0] shadow_r [MAP_SIZE];
  logic [7:0] shadow_nxt [MAP_SIZE];
  logic [7:0] ee_r [MAP_SIZE];
  logic [7:0] ee_nxt [MAP_SIZE];
  logic conv_r, conv_nxt, cont_r, cont_nxt, done_r, done_nxt;
  logic [31:0] tmr_r, tmr_nxt, conv_lim;
  logic cp_r, cp_nxt, rc_r, rc_nxt;
  logic [3:0] bits_r, bits_nxt;
  logic res_hi_r, res_lo_r, single_r;
  logic byte_done, word_done, is_cmd, wr_fire, ld_fire;
  logic cmd_start, cmd_stop, cmd_recall, cmd_copy, cmd_por;
  logic [6:0] own_addr;
  logic [7:0] rd_byte, ptr_inc, cfg;

  // Decode of the byte just shifted in and of the read source
  always_comb begin
    byte_done = pins.scl_fall && (cnt_r == BITS_PER_BYTE);
    own_addr = {OWN_ADDR_HI, pins.addr};
    word_done = (st_r == ST_WORD) && byte_done;
    is_cmd = (sh_r == CMD_START) || (sh_r == CMD_STOP) ||
             (sh_r == CMD_RECALL) || (sh_r == CMD_COPY) ||
             (sh_r == CMD_POR);
    cmd_start = word_done && (sh_r == CMD_START);
    cmd_stop = word_done && (sh_r == CMD_STOP);
    cmd_recall = word_done && (sh_r == CMD_RECALL);
    cmd_copy = word_done && (sh_r == CMD_COPY);
    cmd_por = word_done && (sh_r == CMD_POR);
    wr_fire = (st_r == ST_DATA) && byte_done;
    ld_fire = pins.scl_fall && (((st_r == ST_CACK) && rd_r) ||
              ((st_r == ST_MACK) && !sh_r[0]));
    // Pointer sticks at the top so reads never wrap into the map
    ptr_inc = (ptr_r == PTR_MAX) ? ptr_r : ptr_r + 8'h01;
    rd_byte = ttc_in_map(ptr_r) ? shadow_r[ttc_idx(ptr_r)]
                                : FILL_BYTE;
    cfg = shadow_r[ttc_idx(CFG_ADDR)];
  end

  // Bus state machine: sample on SCL rise, drive and decide on fall
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    tx_nxt = tx_r;
    rd_nxt = rd_r;
    oe_nxt = oe_r;
    if (pins.start) begin
      st_nxt = ST_CTRL;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else if (pins.stop) begin
      st_nxt = ST_IDLE;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else begin
      if (pins.scl_rise && (st_r != ST_IDLE) && (st_r != ST_SKIP)) begin
        sh_nxt = {sh_r[6:0], pins.sda};
        cnt_nxt = cnt_r + 4'h1;
      end
      if (pins.scl_fall) begin
        case (st_r)
          ST_CTRL: begin
            if (byte_done) begin
              if (sh_r[7:1] == own_addr) begin
                st_nxt = ST_CACK;
                oe_nxt = 1'b1;
                rd_nxt = sh_r[0];
              end else begin
                st_nxt = ST_SKIP;
              end
            end
          end
          ST_WORD: begin
            if (byte_done) begin
              st_nxt = ST_WACK;
              oe_nxt = 1'b1;
              if (!is_cmd) begin
                ptr_nxt = sh_r;
              end
            end
          end
          ST_DATA: begin
            if (byte_done) begin
              st_nxt = ST_DACK;
              oe_nxt = 1'b1;
              ptr_nxt = ptr_inc;
            end
          end
          ST_CACK: begin
            cnt_nxt = 4'h0;
            if (!rd_r) begin
              oe_nxt = 1'b0;
              st_nxt = ST_WORD;
            end
          end
          ST_WACK, ST_DACK: begin
            cnt_nxt = 4'h0;
            oe_nxt = 1'b0;
            st_nxt = ST_DATA;
          end
          ST_TX: begin
            if (byte_done) begin
              oe_nxt = 1'b0;
              cnt_nxt = 4'h0;
              st_nxt = ST_MACK;
            end else begin
              oe_nxt = ~tx_r[7];
              tx_nxt = {tx_r[6:0], 1'b0};
            end
          end
          ST_MACK: begin
            cnt_nxt = 4'h0;
            if (sh_r[0]) begin
              st_nxt = ST_SKIP;
            end
          end
          default: begin
          end
        endcase
        // Load the next read byte and drive its MSB right away
        if (ld_fire) begin
          st_nxt = ST_TX;
          oe_nxt = ~rd_byte[7];
          tx_nxt = {rd_byte[6:0], 1'b0};
          ptr_nxt = ptr_inc;
        end
      end
    end
  end

  // Storage, commands and conversion timer; soft reset wins last
  always_comb begin
    shadow_nxt = shadow_r;
    ee_nxt = ee_r;
    conv_nxt = conv_r;
    cont_nxt = cont_r;
    tmr_nxt = tmr_r;
    done_nxt = 1'b0;
    cp_nxt = cmd_copy;
    rc_nxt = cmd_recall;
    conv_lim = 32'(CONV_UNIT_CYC) << cfg[CFG_RES_HI:CFG_RES_LO];
    // Only whole bytes reach here; A8h, A9h and temperature are skipped
    if (wr_fire && ttc_is_nv(ptr_r)) begin
      shadow_nxt[ttc_idx(ptr_r)] = sh_r;
    end
    if (conv_r) begin
      if (tmr_r >= conv_lim - 32'h1) begin
        done_nxt = 1'b1;
        tmr_nxt = 32'h0;
        shadow_nxt[ttc_idx(TEMP_MSB)] = temp_in[15:8];
        shadow_nxt[ttc_idx(TEMP_LSB)] = temp_in[7:0];
        if (!cont_r) begin
          conv_nxt = 1'b0;
        end
      end else begin
        tmr_nxt = tmr_r + 32'h1;
      end
    end
    if (cmd_start) begin
      conv_nxt = 1'b1;
      cont_nxt = ~cfg[CFG_SINGLE];
      tmr_nxt = 32'h0;
    end
    if (cmd_stop && !cfg[CFG_SINGLE]) begin
      conv_nxt = 1'b0;
    end
    for (int i = 0; i < MAP_SIZE; i++) begin
      if (ttc_is_nv(MAP_FIRST + 8'(i))) begin
        if (cmd_copy) begin
          ee_nxt[i] = shadow_r[i];
        end
        if (cmd_recall) begin
          shadow_nxt[i] = ee_r[i];
        end
      end
      if (cmd_por) begin
        shadow_nxt[i] = ee_r[i];
      end
    end
    if (cmd_por) begin
      conv_nxt = 1'b0;
      cont_nxt = 1'b0;
      tmr_nxt = 32'h0;
    end
    bits_nxt = RES_BASE_BITS + {2'b00, cfg[CFG_RES_HI:CFG_RES_LO]};
  end

  // Registers; EEPROM starts from factory values at power-up
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      tx_r <= 8'h00;
      rd_r <= 1'b0;
      oe_r <= 1'b0;
      for (int i = 0; i < MAP_SIZE; i++) begin
        shadow_r[i] <= ttc_factory(i);
        ee_r[i] <= ttc_factory(i);
      end
      conv_r <= 1'b0;
      cont_r <= 1'b0;
      tmr_r <= 32'h0;
      done_r <= 1'b0;
      cp_r <= 1'b0;
      rc_r <= 1'b0;
      bits_r <= RES_BASE_BITS;
      res_hi_r <= 1'b0;
      res_lo_r <= 1'b0;
      single_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      tx_r <= tx_nxt;
      rd_r <= rd_nxt;
      oe_r <= oe_nxt;
      shadow_r <= shadow_nxt;
      ee_r <= ee_nxt;
      conv_r <= conv_nxt;
      cont_r <= cont_nxt;
      tmr_r <= tmr_nxt;
      done_r <= done_nxt;
      cp_r <= cp_nxt;
      rc_r <= rc_nxt;
      bits_r <= bits_nxt;
      res_hi_r <= cfg[CFG_RES_HI];
      res_lo_r <= cfg[CFG_RES_LO];
      single_r <= cfg[CFG_SINGLE];
    end
  end

  // Open drain: the data output is a constant low, only enable moves
  assign sda_o = 1'b0;
  assign sda_oe = oe_r;
  assign converting = conv_r;
  assign conv_done = done_r;
  assign conv_bits = bits_r;
  assign resolution_select_hi = res_hi_r;
  assign resolution_select_lo = res_lo_r;
  assign single_conversion_mode = single_r;
  assign ee_copy = cp_r;
  assign ee_recall = rc_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // The release edge has no earlier configuration sample to compare with
  AST_RES_BITS: assert property (
    rstn |=> (conv_bits == RES_BASE_BITS +
         {2'b00, $past(cfg[CFG_RES_HI:CFG_RES_LO])}))
    else $error("width code does not follow resolution bits");
  AST_CONV_MAX: assert property (conv_r |-> tmr_r < conv_lim)
    else $error("conversion ran past its maximum time");
  AST_START_SYNC: assert property (
    pins.start |=> (st_r == ST_CTRL) && (cnt_r == 4'h0) && !oe_r)
    else $error("start did not resynchronise the receiver");
  AST_STOP_IDLE: assert property (
    pins.stop |=> (st_r == ST_IDLE) && !oe_r)
    else $error("stop did not release and idle");
  AST_NO_MATCH: assert property (
    ((st_r == ST_CTRL) && byte_done && !pins.start && !pins.stop &&
     (sh_r[7:1] != own_addr)) |=> (st_r == ST_SKIP) && !oe_r)
    else $error("foreign address was not ignored");
  AST_MATCH_ACK: assert property (
    ((st_r == ST_CTRL) && byte_done && !pins.start && !pins.stop &&
     (sh_r[7:1] == own_addr)) |=> oe_r && (st_r == ST_CACK))
    else $error("own address not acknowledged");
  AST_ACK_HOLD: assert property (
    (oe_r && (st_r == ST_WACK) && !pins.scl_fall && !pins.start &&
     !pins.stop) |=> oe_r)
    else $error("acknowledge dropped before SCL fell");
  AST_OE_SCL_LOW: assert property (
    ($changed(oe_r) && !$past(pins.start) && !$past(pins.stop))
    |-> !$past(pins.scl))
    else $error("SDA driven while SCL high");
  AST_UNDEF_WR: assert property (
    (wr_fire && ((ptr_r == UNDEF_A) || (ptr_r == UNDEF_B)) && !cmd_por)
    |=> (shadow_r[ttc_idx(UNDEF_A)] == $past(shadow_r[ttc_idx(UNDEF_A)])) &&
        (shadow_r[ttc_idx(UNDEF_B)] == $past(shadow_r[ttc_idx(UNDEF_B)])))
    else $error("write to undefined location changed storage");
  AST_READ_FILL: assert property (
    (ld_fire && !pins.start && !pins.stop && (ptr_r > MAP_LAST))
    |=> !oe_r && (tx_r == 8'hFE))
    else $error("read past the map did not return all ones");
  AST_STOP_CMD: assert property (
    (cmd_stop && !cfg[CFG_SINGLE]) |=> !conv_r)
    else $error("stop command left conversion running");

  COV_WRITE: cover property (wr_fire && ttc_is_nv(ptr_r));
  COV_READ: cover property (ld_fire ##[1:1000] (st_r == ST_MACK));
  COV_NACK: cover property ((st_r == ST_MACK) && pins.scl_fall && sh_r[0]);
  COV_CONV: cover property (done_r && cont_r);
endmodule

// ==== tb/ttc_master.sv ====
// Behavioural two-wire bus master driving SCL and pulling SDA low.
// Assumes SDA has a pull-up: the bench resolves the wire from all pulls.
`timescale 1ns/1ps
module ttc_master (
  input wire logic mclk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  // Idle bus: SCL high, SDA released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // One SCL period of 13 mclk; SDA moves only mid-low
  task automatic bit_io(input logic b, output logic s);
    scl <= 1'b0;
    tk(3);
    sda_pull <= ~b;
    tk(4);
    scl <= 1'b1;
    tk(3);
    s = sda_line;
    tk(3);
  endtask

  // Also serves as a repeated start
  task automatic start();
    scl <= 1'b0;
    tk(3);
    sda_pull <= 1'b0;
    tk(4);
    scl <= 1'b1;
    tk(3);
    sda_pull <= 1'b1;
    tk(4);
  endtask

  // Leaves both lines high afterwards
  task automatic stop();
    scl <= 1'b0;
    tk(3);
    sda_pull <= 1'b1;
    tk(4);
    scl <= 1'b1;
    tk(3);
    sda_pull <= 1'b0;
    tk(6);
  endtask

  // Eight bits MSB first, then released for the ack
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, ack);
  endtask

  // A high ack after the final byte ends the read
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask
endmodule

// ==== tb/tb_ttc_top.sv ====
// Self-checking bench for the command port: bus transfers, commands
// and conversion control. Assumes a 200 MHz mclk and a shortened timer.
`timescale 1ns/1ps
module tb_ttc_top;
  import ttc_pkg::*;
  localparam int UNIT = 20;
  localparam logic [2:0] PINS = 3'h5;
  localparam logic [7:0] DEV_W = {OWN_ADDR_HI, PINS, 1'b0};
  logic mclk, rstn, m_scl, m_pull, sda_o, sda_oe, converting, conv_done;
  logic resolution_select_hi, resolution_select_lo, single_conversion_mode;
  logic ee_copy, ee_recall;
  logic [3:0] conv_bits;
  logic [15:0] temp_in;
  logic [2:0] addr_pins;
  wire sda_line = (sda_oe ? sda_o : 1'b1) & ~m_pull;
  int num_errors = 0, compares = 0, n_done = 0, n_copy = 0, n_recall = 0;
  int run = 0, last_len = 0;

  ttc_master m (.mclk(mclk), .sda_line(sda_line), .scl(m_scl),
    .sda_pull(m_pull));
  ttc_top #(.CONV_UNIT_CYC(UNIT)) dut (.mclk(mclk), .rstn(rstn),
    .scl_in(m_scl), .sda_in(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_pin_bit2(addr_pins[2]), .addr_pin_bit1(addr_pins[1]),
    .addr_pin_bit0(addr_pins[0]), .temp_in(temp_in), .converting(converting),
    .conv_done(conv_done), .conv_bits(conv_bits),
    .resolution_select_hi(resolution_select_hi),
    .resolution_select_lo(resolution_select_lo),
    .single_conversion_mode(single_conversion_mode),
    .ee_copy(ee_copy), .ee_recall(ee_recall));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Strobes last one cycle, so they are counted rather than polled;
  // the falling edge keeps the count clear of the launching edge
  always @(negedge mclk) begin
    if (conv_done === 1'b1) begin
      n_done++;
      last_len = run;
    end
    if (ee_copy === 1'b1) n_copy++;
    if (ee_recall === 1'b1) n_recall++;
    run = (converting === 1'b1 && conv_done !== 1'b1) ? run + 1 : 0;
  end

  task automatic give_verdict();
    if (num_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wb(input logic [7:0] b);
    logic a;
    m.wbyte(b, a);
    check("ack", a, 1'b0);
  endtask

  // Write transfer; an empty data list makes a command
  task automatic wr(input logic [7:0] a, input logic [7:0] d [$]);
    m.start();
    wb(DEV_W);
    wb(a);
    foreach (d[i]) wb(d[i]);
    m.stop();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e [$]);
    logic [7:0] d;
    m.start();
    wb(DEV_W);
    wb(a);
    m.start();
    wb(DEV_W | 8'h01);
    foreach (e[i]) begin
      m.rbyte(i == e.size() - 1, d);
      check("rdata", d, e[i]);
    end
    m.stop();
  endtask

  // Packed as resolution hi, lo, single mode, converting
  task automatic cfg_is(input logic [3:0] e, input logic [3:0] bits);
    @(negedge mclk);
    check("cfg", {resolution_select_hi, resolution_select_lo,
      single_conversion_mode, converting}, e);
    check("conv_bits", conv_bits, bits);
  endtask

  task automatic wait_done(input int target);
    int k;
    k = 0;
    while (n_done < target && k < 2000) begin
      @(negedge mclk);
      k++;
    end
    if (k >= 2000) begin
      num_errors++;
      give_verdict();
    end
  endtask

  // Timer length may shift a cycle or two with pipeline latency
  task automatic len_is(input int n);
    check("conv_len", (last_len + 2 >= n) && (last_len <= n + 2), 1'b1);
  endtask

  initial begin
    logic [7:0] c;
    logic a;
    int t;
    rstn = 1'b0;
    temp_in = 16'h0000;
    addr_pins = PINS;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    repeat (10) @(posedge mclk);
    cfg_is(4'hC, 4'hD);
    // Every address-pin value plus a wrong fixed nibble
    for (int i = 0; i < 9; i++) begin
      c = (i < 8) ? {OWN_ADDR_HI, 3'(i), 1'b0} : {4'h1, PINS, 1'b0};
      m.start();
      m.wbyte(c, a);
      check("addr_ack", a, c != DEV_W);
      m.wbyte(8'hA0, a);
      check("skip_ack", a, c != DEV_W);
      m.stop();
    end
    // Device follows a change on its address pins
    addr_pins <= 3'h2;
    repeat (10) @(posedge mclk);
    m.start();
    m.wbyte({OWN_ADDR_HI, 3'h2, 1'b0}, a);
    check("pin_ack", a, 1'b0);
    m.stop();
    addr_pins <= PINS;
    repeat (10) @(posedge mclk);
    wr(8'hA4, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66});
    rd(8'hA4, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'h00});
    rd(8'hAD, '{8'h00, 8'hFF, 8'hFF});
    // Byte cut short by a repeated start must not land
    m.start();
    wb(DEV_W);
    wb(8'hA5);
    repeat (4) m.bit_io(1'b0, a);
    m.start();
    wb(DEV_W);
    wb(8'hA6);
    m.stop();
    rd(8'hA4, '{8'h11, 8'h22, 8'h33});
    // Continuous run at 11 bits, copy while converting
    temp_in <= 16'hC3A5;
    wr(CFG_ADDR, '{8'h04});
    cfg_is(4'h4, 4'hB);
    wr(CMD_START, '{});
    cfg_is(4'h5, 4'hB);
    wait_done(n_done + 2);
    len_is(UNIT << 1);
    wr(CMD_COPY, '{});
    check("copies", 16'(n_copy), 16'h0001);
    rd(TEMP_MSB, '{8'hC3, 8'hA5});
    wr(CFG_ADDR, '{8'h05});
    wait_done(n_done + 2);
    cfg_is(4'h7, 4'hB);
    wr(CMD_STOP, '{});
    cfg_is(4'h7, 4'hB);
    wr(8'hA4, '{8'h77});
    wr(CMD_POR, '{});
    cfg_is(4'h4, 4'hB);
    rd(8'hA4, '{8'h11});
    // Recall restores the stored image over a shadow write
    wr(8'hA4, '{8'h88});
    wr(CMD_RECALL, '{});
    check("recalls", 16'(n_recall), 16'h0001);
    rd(8'hA4, '{8'h11});
    wr(CMD_START, '{});
    cfg_is(4'h5, 4'hB);
    wr(CMD_STOP, '{});
    cfg_is(4'h4, 4'hB);
    // One-shot at 10 bits stops after a single conversion
    wr(CFG_ADDR, '{8'h01});
    cfg_is(4'h2, 4'hA);
    t = n_done;
    wr(CMD_START, '{});
    wait_done(t + 1);
    repeat (2 * UNIT) @(negedge mclk);
    cfg_is(4'h2, 4'hA);
    check("one_shot", 16'(n_done - t), 16'h0001);
    len_is(UNIT);
    give_verdict();
  end
endmodule
